/* File: design/utxb_defines.svh */
// Purpose: Offsets, field positions, reset values and counts of the transmit channel
// Assumes: Register port with a 4-bit address and 8-bit data
// Notes: Definitions only
`ifndef UTXB_DEFINES_SVH
`define UTXB_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UTXB_ADDR_HOLD 4'h0
`define UTXB_ADDR_IRQ_EN 4'h1
`define UTXB_ADDR_IRQ_ST 4'h2
`define UTXB_ADDR_FIFO_CTL 4'h3
`define UTXB_ADDR_LCR 4'h4
`define UTXB_ADDR_MODEM_CTL 4'h5
`define UTXB_ADDR_LINE_ST 4'h6
`define UTXB_ADDR_DLL 4'h7
`define UTXB_ADDR_DIV_HI 4'h8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UTXB_IRQ_EN_RX 0
`define UTXB_IRQ_EN_TX 1
`define UTXB_IRQ_ST_NONE 0
`define UTXB_IRQ_ST_TX 1
`define UTXB_IRQ_ST_RX 2
`define UTXB_FIFO_EN 0
`define UTXB_FIFO_TXCLR 2
`define UTXB_FIFO_DMA 3
`define UTXB_LCR_STOP2 2
`define UTXB_LCR_PEN 3
`define UTXB_LCR_EVEN 4
`define UTXB_LINE_THRE 5
`define UTXB_LINE_TEMT 6
`define UTXB_MODEM_PRE4 7

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define UTXB_RST_BYTE 8'h00
`define UTXB_RST_PIN_HIGH 1'b1
`define UTXB_FIFO_DEPTH 5'h10
`define UTXB_BIT_LAST 4'hf
`define UTXB_PRE_LAST 2'h3

`endif

/* File: design/utxb_pkg.sv */
// Purpose: Types shared by the transmit channel modules
// Assumes: Nothing beyond the defines header
// Notes: All state of the channel and of the baud generator is one packed struct each; the byte store keeps a plain array
package utxb_pkg;

    // ----------------------------------------
    // Transmitter sequencer
    // ----------------------------------------
    typedef enum logic [2:0] {TX_IDLE, TX_LOAD, TX_START, TX_DATA, TX_PAR, TX_STOP} utxb_tx_state_type;

    // ----------------------------------------
    // Status handed over by the receiver
    // ----------------------------------------
    typedef struct packed {
        logic [4:0] level;
        logic trig_hit;
        logic timeout;
    } utxb_rx_stat_type;

    // ----------------------------------------
    // Channel state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] irq_en;
        logic [7:0] fifo_ctl;
        logic [7:0] lcr;
        logic [7:0] modem_ctl;
        logic [7:0] dll;
        logic [7:0] div_hi;
        logic [3:0] wp;
        logic [3:0] rp;
        logic [4:0] cnt;
        utxb_tx_state_type st;
        logic [7:0] shf;
        logic [2:0] bitn;
        logic [3:0] tcnt;
        logic par;
        logic line;
        logic [7:0] rdata;
        logic tx_rdy_n;
        logic rx_rdy_n;
        logic rx_flag;
        logic irq;
    } utxb_chan_state_type;

    // ----------------------------------------
    // Baud generator state
    // ----------------------------------------
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [1:0] pre;
        logic [15:0] div;
        logic tick;
    } utxb_baud_state_type;

endpackage : utxb_pkg

/* File: design/utxb_mem.sv */
// Purpose: Byte store behind the transmit FIFO
// Assumes: One write port, one read port, same clock
// Notes: Read data come out of a register one cycle after the address
`timescale 1ns/100ps
module utxb_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // Clock
    input wire logic clk,
    // Write side
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read side
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Storage has no reset; pointers decide what is valid
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule : utxb_mem

/* File: design/utxb_baud.sv */
// Purpose: Prescaler and divisor giving the 16x tick of one channel
// Assumes: osc_in is far slower than clk and unrelated to it
// Notes: Divisor zero stops the tick
`timescale 1ns/100ps
`include "utxb_defines.svh"
module utxb_baud (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Oscillator pin
    input wire logic osc_in,
    // Settings
    input wire logic pre4,
    input wire logic [15:0] divisor,
    // Output
    output logic tick
);

    utxb_pkg::utxb_baud_state_type s_reg, s_next;
    logic osc_rise;
    logic pre_en;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    // Pin passes two flops before the edge detector looks at it
    always_comb begin
        s_next = s_reg;
        s_next.sync1 = osc_in;
        s_next.sync2 = s_reg.sync1;
        s_next.prev = s_reg.sync2;
        s_next.tick = 1'b0;
        osc_rise = s_reg.sync2 && !s_reg.prev;
        pre_en = osc_rise && (!pre4 || s_reg.pre == `UTXB_PRE_LAST);
        if (osc_rise) begin
            s_next.pre = s_reg.pre + 2'h1;
        end
        if (pre_en && divisor != 16'h0000) begin
            if (s_reg.div >= divisor - 16'h0001) begin
                s_next.div = 16'h0000;
                s_next.tick = 1'b1;
            end else begin
                s_next.div = s_reg.div + 16'h0001;
            end
        end
    end

    // Register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_TICK_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst) tick |=> !tick)
        else $error("16x tick longer than one cycle");
    AST_TICK_ZERO_DIV: assert property (@(posedge clk) disable iff (rst)
        (divisor == 16'h0000)[*2] |-> !tick)
        else $error("Tick with zero divisor");

endmodule : utxb_baud

/* File: design/utxb_chan.sv */
// Purpose: Transmit path, baud divisor and ready/interrupt pins of one serial channel
// Assumes: Receiver of the same channel supplies level, trigger and timeout on clk
// Notes: Non-FIFO mode uses the same store with room for one byte
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "utxb_defines.svh"

// Behaviour
// - FIFO on, block mode off: receive-ready low while receive FIFO holds data
// - Block mode: receive-ready falls on trigger or timeout, rises when FIFO empties
// - FIFO on, block mode off: transmit-ready low only while transmit FIFO empty
// - Block mode: transmit-ready low while any free location, high when full
// - Interrupt pin high when holding register or transmit FIFO is empty and enable bit 1 is set
// - Receive interrupt: above trigger with FIFO, one byte held without FIFO
// - Baud generator runs from the oscillator pin; register access needs no oscillator
// - Input clock divided by 16-bit divisor 1..65535 to form the 16x tick
// - Divisor is high byte register joined with low byte register
// - One baud tick times both transmitter and receiver
// - Shifter sends one bit per sixteen 16x ticks
// - Character is start, data bits, optional parity, then stop bits
// - Bit 0 of each written byte goes out first
// - Holding register write pushes one byte into the 16-entry FIFO
// - Non-FIFO: holding-empty flag set when byte moves into the shifter
// - Holding-empty raises status bit 1 interrupt only when enable bit 1 set
// - Non-FIFO: transmitter-empty flag set only after the shifter finishes
// - FIFO mode: holding-empty when FIFO empty; transmitter-empty when both empty
// - Prescaler divides by 1 or 4; by 1 when modem control bit 7 clear
module utxb_chan (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Oscillator pin
    input wire logic osc_in,
    // Receiver status
    input wire utxb_pkg::utxb_rx_stat_type rx_stat,
    // Serial line and pins
    output logic tx_out,
    output logic tx_ready_n,
    output logic rx_ready_n,
    output logic irq_chan_a,
    output logic baud_tick16
);

    utxb_pkg::utxb_chan_state_type s_reg, s_next;
    logic tick;
    logic [7:0] mem_rdata;
    logic fifo_en;
    logic dma;
    logic empty;
    logic full;
    logic push;
    logic pop;
    logic clear;
    logic bit_end;
    logic thre;
    logic temt;
    logic tx_irq;
    logic rx_irq;
    logic [4:0] limit;
    logic [2:0] last_bit;
    logic [7:0] mask;

    // ----------------------------------------
    // Baud generator and byte store
    // ----------------------------------------
    // Divisor formed from the two byte registers
    utxb_baud u_baud (
        .clk(clk),
        .rst(rst),
        .osc_in(osc_in),
        .pre4(s_reg.modem_ctl[`UTXB_MODEM_PRE4]),
        .divisor({s_reg.div_hi, s_reg.dll}),
        .tick(tick)
    );

    utxb_mem #(
        .WIDTH(8),
        .DEPTH(16),
        .AW(4)
    ) u_mem (
        .clk(clk),
        .we(push),
        .waddr(s_reg.wp),
        .wdata(wdata),
        .raddr(s_reg.rp),
        .rdata(mem_rdata)
    );

    // ----------------------------------------
    // Derived conditions
    // ----------------------------------------
    // Mode bits and store levels
    assign fifo_en = s_reg.fifo_ctl[`UTXB_FIFO_EN];
    assign dma = fifo_en && s_reg.fifo_ctl[`UTXB_FIFO_DMA];
    assign empty = s_reg.cnt == 5'h00;
    assign full = s_reg.cnt == `UTXB_FIFO_DEPTH;
    assign limit = fifo_en ? `UTXB_FIFO_DEPTH : 5'h01;
    assign bit_end = tick && s_reg.tcnt == `UTXB_BIT_LAST;
    assign last_bit = 3'h4 + {1'b0, s_reg.lcr[1:0]}; // Index of the final data bit, 4..7
    assign mask = 8'hff >> (2'h3 - s_reg.lcr[1:0]);

    // Flags in the line status register
    assign thre = empty;
    assign temt = empty && s_reg.st == utxb_pkg::TX_IDLE;

    // Interrupt sources
    assign tx_irq = s_reg.irq_en[`UTXB_IRQ_EN_TX] && thre;
    assign rx_irq = s_reg.irq_en[`UTXB_IRQ_EN_RX]
        && (fifo_en ? (rx_stat.trig_hit || rx_stat.timeout) : rx_stat.level != 5'h00);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    // Register writes, store bookkeeping, shifter and pins
    always_comb begin
        s_next = s_reg;
        s_next.rdata = 8'h00;
        clear = 1'b0;
        pop = 1'b0;
        // Over-full writes are dropped; in non-FIFO mode the host waits for empty
        push = wr && addr == `UTXB_ADDR_HOLD && s_reg.cnt < limit;

        // Register writes
        if (wr) begin
            case (addr)
                `UTXB_ADDR_IRQ_EN: begin
                    s_next.irq_en = wdata;
                end
                `UTXB_ADDR_FIFO_CTL: begin
                    // Toggling the enable also flushes, so stale bytes never leak across modes
                    clear = wdata[`UTXB_FIFO_TXCLR] || wdata[`UTXB_FIFO_EN] != fifo_en;
                    s_next.fifo_ctl = wdata;
                    s_next.fifo_ctl[`UTXB_FIFO_TXCLR] = 1'b0;
                end
                `UTXB_ADDR_LCR: begin
                    s_next.lcr = wdata;
                end
                `UTXB_ADDR_MODEM_CTL: begin
                    s_next.modem_ctl = wdata;
                end
                `UTXB_ADDR_DLL: begin
                    s_next.dll = wdata;
                end
                `UTXB_ADDR_DIV_HI: begin
                    s_next.div_hi = wdata;
                end
                default: begin
                end
            endcase
        end

        // Register reads, answered one cycle later
        if (rd) begin
            case (addr)
                `UTXB_ADDR_IRQ_EN: begin
                    s_next.rdata = s_reg.irq_en;
                end
                `UTXB_ADDR_IRQ_ST: begin
                    s_next.rdata[`UTXB_IRQ_ST_NONE] = !(tx_irq || rx_irq);
                    s_next.rdata[`UTXB_IRQ_ST_TX] = tx_irq;
                    s_next.rdata[`UTXB_IRQ_ST_RX] = rx_irq;
                end
                `UTXB_ADDR_LCR: begin
                    s_next.rdata = s_reg.lcr;
                end
                `UTXB_ADDR_MODEM_CTL: begin
                    s_next.rdata = s_reg.modem_ctl;
                end
                `UTXB_ADDR_LINE_ST: begin
                    s_next.rdata[`UTXB_LINE_THRE] = thre;
                    s_next.rdata[`UTXB_LINE_TEMT] = temt;
                end
                `UTXB_ADDR_DLL: begin
                    s_next.rdata = s_reg.dll;
                end
                `UTXB_ADDR_DIV_HI: begin
                    s_next.rdata = s_reg.div_hi;
                end
                default: begin
                end
            endcase
        end

        // Bit timer runs on the shared 16x tick
        if (tick && s_reg.st != utxb_pkg::TX_IDLE && s_reg.st != utxb_pkg::TX_LOAD) begin
            s_next.tcnt = s_reg.tcnt + 4'h1;
        end

        // Shifter sequence; idle waits a cycle so the store read settles
        unique case (s_reg.st)
            utxb_pkg::TX_IDLE: begin
                if (!empty) begin
                    s_next.st = utxb_pkg::TX_LOAD;
                end
            end
            utxb_pkg::TX_LOAD: begin
                pop = 1'b1;
                s_next.shf = mem_rdata;
                s_next.par = ^(mem_rdata & mask) ^ !s_reg.lcr[`UTXB_LCR_EVEN];
                s_next.tcnt = 4'h0;
                s_next.line = 1'b0;
                s_next.st = utxb_pkg::TX_START;
            end
            utxb_pkg::TX_START: begin
                if (bit_end) begin
                    s_next.bitn = 3'h0;
                    s_next.line = s_reg.shf[0];
                    s_next.st = utxb_pkg::TX_DATA;
                end
            end
            utxb_pkg::TX_DATA: begin
                if (bit_end) begin
                    s_next.shf = s_reg.shf >> 1;
                    if (s_reg.bitn == last_bit) begin
                        s_next.bitn = 3'h0;
                        if (s_reg.lcr[`UTXB_LCR_PEN]) begin
                            s_next.line = s_reg.par;
                            s_next.st = utxb_pkg::TX_PAR;
                        end else begin
                            s_next.line = 1'b1;
                            s_next.st = utxb_pkg::TX_STOP;
                        end
                    end else begin
                        s_next.bitn = s_reg.bitn + 3'h1;
                        s_next.line = s_reg.shf[1];
                    end
                end
            end
            utxb_pkg::TX_PAR: begin
                if (bit_end) begin
                    s_next.line = 1'b1;
                    s_next.st = utxb_pkg::TX_STOP;
                end
            end
            utxb_pkg::TX_STOP: begin
                if (bit_end) begin
                    if (s_reg.lcr[`UTXB_LCR_STOP2] && s_reg.bitn == 3'h0) begin
                        s_next.bitn = 3'h1;
                    end else begin
                        s_next.st = utxb_pkg::TX_IDLE;
                    end
                end
            end
        endcase

        // Store pointers and level
        if (clear) begin
            s_next.wp = 4'h0;
            s_next.rp = 4'h0;
            s_next.cnt = 5'h00;
        end else begin
            if (push) begin
                s_next.wp = s_reg.wp + 4'h1;
            end
            if (pop) begin
                s_next.rp = s_reg.rp + 4'h1;
            end
            if (push && !pop) begin
                s_next.cnt = s_reg.cnt + 5'h01;
            end else if (pop && !push) begin
                s_next.cnt = s_reg.cnt - 5'h01;
            end
        end

        // Transmit-ready pin
        if (dma) begin
            s_next.tx_rdy_n = full;
        end else begin
            s_next.tx_rdy_n = !empty;
        end

        // Receive-ready pin; a new trigger wins over the empty clear
        if (rx_stat.trig_hit || rx_stat.timeout) begin
            s_next.rx_flag = 1'b1;
        end else if (rx_stat.level == 5'h00) begin
            s_next.rx_flag = 1'b0;
        end
        if (dma) begin
            s_next.rx_rdy_n = !s_reg.rx_flag;
        end else begin
            s_next.rx_rdy_n = rx_stat.level == 5'h00;
        end

        // Interrupt pin
        s_next.irq = tx_irq || rx_irq;
    end

    // ----------------------------------------
    // Register
    // ----------------------------------------
    // Reset leaves the line idle high and the receive pin showing no data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.line <= `UTXB_RST_PIN_HIGH;
            s_reg.rx_rdy_n <= `UTXB_RST_PIN_HIGH;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from flops
    assign rdata = s_reg.rdata;
    assign tx_out = s_reg.line;
    assign tx_ready_n = s_reg.tx_rdy_n;
    assign rx_ready_n = s_reg.rx_rdy_n;
    assign irq_chan_a = s_reg.irq;
    assign baud_tick16 = tick;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_RX_READY_N_FIFO: assert property (fifo_en && !dma && rx_stat.level != 5'h00 |=> !rx_ready_n)
        else $error("Receive-ready high with data present");
    AST_RX_READY_N_DMA: assert property (dma && rx_stat.trig_hit ##1 dma |=> !rx_ready_n)
        else $error("Receive-ready did not fall on trigger");
    AST_TX_READY_N_FIFO: assert property (fifo_en && !dma && s_reg.cnt != 5'h00 |=> tx_ready_n)
        else $error("Transmit-ready low with bytes present");
    AST_TX_READY_N_DMA: assert property (dma && !full |=> !tx_ready_n)
        else $error("Transmit-ready high with free room");
    AST_IRQ_TX: assert property (s_reg.irq_en[`UTXB_IRQ_EN_TX] && empty |=> irq_chan_a)
        else $error("No interrupt with transmitter empty");
    AST_IRQ_RX: assert property (s_reg.irq_en[`UTXB_IRQ_EN_RX] && fifo_en && rx_stat.trig_hit |=> irq_chan_a)
        else $error("No interrupt at receive trigger");
    AST_START_LOW: assert property (s_reg.st == utxb_pkg::TX_LOAD |=> (!tx_out) [*8])
        else $error("Start bit not held low");
    AST_LSB_FIRST: assert property (s_reg.st == utxb_pkg::TX_START && bit_end |=> tx_out == $past(s_reg.shf[0]))
        else $error("First data bit is not bit 0");
    AST_PUSH_COUNT: assert property (push && !pop && !clear |=> s_reg.cnt == $past(s_reg.cnt) + 5'h01)
        else $error("Holding write did not add one byte");
    AST_TEMT_BUSY: assert property (rd && addr == `UTXB_ADDR_LINE_ST && s_reg.st != utxb_pkg::TX_IDLE
        |=> !rdata[`UTXB_LINE_TEMT])
        else $error("Transmitter-empty set while shifting");

    COV_FRAME_END: cover property (s_reg.st == utxb_pkg::TX_STOP && bit_end);
    COV_FIFO_FULL: cover property (fifo_en && full);
    COV_DMA_RX: cover property (dma && !rx_ready_n);

endmodule : utxb_chan

/* File: dv/utxb_remote.sv */
// Purpose: Remote receiver on the far end of the serial line
// Assumes: Shares the channel's 16x tick; 8 data bits, no parity, 1 stop
// Notes: A frame whose stop bit reads low is dropped, not reported
`timescale 1ns/100ps
module utxb_remote (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Line and timing
    input wire logic tick,
    input wire logic line,
    // Received byte
    output logic [7:0] byte_out,
    output logic got
);
    logic busy;
    logic [7:0] cnt;
    logic [3:0] nbit;

    // Mid-cell sampling, first data bit lands in bit 0
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            nbit <= 4'h0;
            byte_out <= 8'h00;
            got <= 1'b0;
        end else begin
            got <= 1'b0;
            if (!busy) begin
                busy <= !line;
                cnt <= 8'h00;
                nbit <= 4'h0;
            end else if (tick) begin
                cnt <= cnt + 8'h01;
                if (cnt[3:0] == 4'h7) begin
                    nbit <= nbit + 4'h1;
                    if (nbit == 4'h9) begin
                        busy <= 1'b0;
                        got <= line;
                    end else if (nbit != 4'h0) begin
                        byte_out <= {line, byte_out[7:1]};
                    end
                end
            end
        end
    end
endmodule : utxb_remote

/* File: dv/utxb_chan_test.sv */
// Purpose: Self-checking bench for the transmit channel
// Assumes: Oscillator pin at a quarter of clk, 8N1 frames apart from one 8E2 frame
// Notes: Register tasks space strobes one idle cycle apart
`timescale 1ns/100ps
`include "utxb_defines.svh"
module utxb_chan_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] osc_cnt = 2'h0;
    utxb_pkg::utxb_rx_stat_type rx_stat = '0;
    logic [7:0] rdata;
    logic [7:0] rx_byte;
    logic tx_out, tx_ready_n, rx_ready_n, irq_chan_a, baud_tick16, got;
    logic [7:0] exp_q[$];
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;

    always #12.5 clk = ~clk;
    // Registered divider keeps osc_in clean of clk-edge races
    always @(posedge clk) osc_cnt <= osc_cnt + 2'h1;

    utxb_chan dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .osc_in(osc_cnt[1]), .rx_stat(rx_stat), .tx_out(tx_out), .tx_ready_n(tx_ready_n),
        .rx_ready_n(rx_ready_n), .irq_chan_a(irq_chan_a), .baud_tick16(baud_tick16));
    utxb_remote far (.clk(clk), .rst(rst), .tick(baud_tick16), .line(tx_out), .byte_out(rx_byte), .got(got));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] val, input logic [15:0] exp);
        tests_run++;
        if (val !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, val, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        // Read data stand only until the next edge
        #1;
        chk({8'h00, rdata}, {8'h00, exp});
    endtask : rd_chk

    // Skips two ticks so a fresh setting has settled, then times one gap
    task automatic tick_gap(input logic [15:0] exp);
        int n;
        n = 0;
        repeat (3) begin
            n = 0;
            do begin
                cyc(1);
                n++;
            end while (baud_tick16 !== 1'b1 && n < 3000);
        end
        chk(n[15:0], exp);
    endtask : tick_gap

    task automatic pins(input logic [1:0] exp);
        cyc(3);
        chk({14'h0000, rx_ready_n, irq_chan_a}, {14'h0000, exp});
    endtask : pins

    task automatic drain;
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        chk(16'(exp_q.size()), 16'h0000);
        cyc(100);
    endtask : drain

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    // ----------------------------------------
    // Checks on the far side and the hang guard
    // ----------------------------------------
    always @(posedge clk) begin
        if (got) begin
            if (exp_q.size() == 0) chk({8'h00, rx_byte}, 16'hffff);
            else chk({8'h00, rx_byte}, {8'h00, exp_q.pop_front()});
        end
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            $display("Error at %0t: run did not finish", $time);
            stop_test();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        cyc(2);
        chk({12'h000, tx_out, tx_ready_n, rx_ready_n, irq_chan_a}, 16'h000a);
        rd_chk(`UTXB_ADDR_LINE_ST, 8'h60);
        $display("Test reset done");
        wr_reg(`UTXB_ADDR_DLL, 8'h01);
        wr_reg(`UTXB_ADDR_LCR, 8'h03);
        tick_gap(16'h0004);
        wr_reg(`UTXB_ADDR_MODEM_CTL, 8'h80);
        tick_gap(16'h0010);
        wr_reg(`UTXB_ADDR_MODEM_CTL, 8'h00);
        wr_reg(`UTXB_ADDR_DLL, 8'h00);
        wr_reg(`UTXB_ADDR_DIV_HI, 8'h01);
        tick_gap(16'h0400);
        wr_reg(`UTXB_ADDR_DIV_HI, 8'h00);
        wr_reg(`UTXB_ADDR_DLL, 8'h01);
        $display("Test baud done");
        wr_reg(`UTXB_ADDR_IRQ_EN, 8'h02);
        pins(2'b11);
        rd_chk(`UTXB_ADDR_IRQ_ST, 8'h02);
        exp_q.push_back(8'ha5);
        wr_reg(`UTXB_ADDR_HOLD, 8'ha5);
        cyc(100);
        rd_chk(`UTXB_ADDR_LINE_ST, 8'h20);
        pins(2'b11);
        drain();
        rd_chk(`UTXB_ADDR_LINE_ST, 8'h60);
        // Even parity of 8'h07 is a high bit, which the far side takes for the stop
        wr_reg(`UTXB_ADDR_LCR, 8'h1f);
        exp_q.push_back(8'h07);
        wr_reg(`UTXB_ADDR_HOLD, 8'h07);
        drain();
        wr_reg(`UTXB_ADDR_LCR, 8'h03);
        $display("Test single done");
        wr_reg(`UTXB_ADDR_FIFO_CTL, 8'h01);
        for (int i = 0; i < 3; i++) begin
            exp_q.push_back(8'h3c << i);
            wr_reg(`UTXB_ADDR_HOLD, 8'h3c << i);
        end
        cyc(2);
        chk({15'h0000, tx_ready_n}, 16'h0001);
        pins(2'b10);
        rd_chk(`UTXB_ADDR_LINE_ST, 8'h00);
        drain();
        chk({15'h0000, tx_ready_n}, 16'h0000);
        wr_reg(`UTXB_ADDR_FIFO_CTL, 8'h09);
        for (int i = 0; i < 17; i++) begin
            exp_q.push_back({i[3:0], ~i[3:0]});
            wr_reg(`UTXB_ADDR_HOLD, {i[3:0], ~i[3:0]});
        end
        cyc(2);
        chk({15'h0000, tx_ready_n}, 16'h0001);
        cyc(700);
        chk({15'h0000, tx_ready_n}, 16'h0000);
        drain();
        $display("Test fifo done");
        // Receive side pins, block mode then single-character, then no FIFO
        wr_reg(`UTXB_ADDR_IRQ_EN, 8'h01);
        rx_stat <= '{level: 5'h03, trig_hit: 1'b0, timeout: 1'b0};
        pins(2'b10);
        rx_stat.trig_hit <= 1'b1;
        pins(2'b01);
        rx_stat.trig_hit <= 1'b0;
        pins(2'b00);
        rx_stat.level <= 5'h00;
        pins(2'b10);
        rx_stat <= '{level: 5'h02, trig_hit: 1'b0, timeout: 1'b1};
        pins(2'b01);
        rx_stat.timeout <= 1'b0;
        wr_reg(`UTXB_ADDR_FIFO_CTL, 8'h01);
        pins(2'b00);
        rx_stat.level <= 5'h00;
        pins(2'b10);
        wr_reg(`UTXB_ADDR_FIFO_CTL, 8'h00);
        rx_stat.level <= 5'h01;
        // Without FIFO the ready pin falls as soon as one byte is held
        pins(2'b01);
        $display("Test pins done");
        stop_test();
    end
endmodule : utxb_chan_test
